/* File: verilog/wdt_pkg.sv */
// watchdog timer constants: register map, field layout, reset values, modes
// assumes an 8-bit register port with a 4-bit word address
package wdt_pkg;

    // =========================================================================
    // register map (word addresses)
    localparam logic [3:0] ADDR_CTRL  = 4'h0;  // period select and soft enable
    localparam logic [3:0] ADDR_EVT   = 4'h1;  // sticky event bits, write one to clear
    localparam logic [3:0] ADDR_MASK  = 4'h2;  // event mask, one passes to irq
    localparam logic [3:0] ADDR_FLAGS = 4'h3;  // read-only live state

    // =========================================================================
    // control register layout
    localparam int         CTRL_EN_BIT = 0;      // soft_watchdog_enable
    localparam int         CTRL_PS_LSB = 1;      // watchdog_period_select low bit
    localparam int         CTRL_PS_MSB = 5;      // watchdog_period_select high bit
    localparam logic [4:0] PS_RESET    = 5'h0b;  // 1:65536, nominal two seconds
    localparam logic       EN_RESET    = 1'b0;   // software enable off
    localparam logic [4:0] PS_MAX      = 5'h12;  // last legal code, 1:8388608
    localparam logic [4:0] PS_MIN      = 5'h00;  // 1:32, used for reserved codes

    // =========================================================================
    // event bits, shared by status and mask
    localparam int EVT_W         = 2;
    localparam int EVT_SLEEP_BIT = 0;  // timeout woke the core from sleep
    localparam int EVT_RST_BIT   = 1;  // timeout while awake, reset issued

    // =========================================================================
    // counter sizing and timing
    localparam int LF_OSC_HZ     = 31000;  // low_freq_internal_osc rate
    localparam int PS_BASE_LOG2  = 5;      // code 00000 divides by 32
    localparam int CNT_W         = 24;     // holds 2^23 ticks
    localparam int FLAG_RESET_TO = 1;      // timeout_status_flag after reset
    localparam int FLAG_RESET_PD = 1;      // powerdown_status_flag after reset

    // =========================================================================
    // mode field and sleep tracking states
    typedef enum logic [1:0] {
        MODE_OFF     = 2'b00,
        MODE_SW      = 2'b01,
        MODE_NOSLEEP = 2'b10,
        MODE_ON      = 2'b11
    } wdt_mode_t;

    typedef enum logic [1:0] {
        ST_AWAKE    = 2'b00,
        ST_SLEEP    = 2'b01,
        ST_OST_HOLD = 2'b10
    } wdt_state_t;

endpackage

/* File: verilog/wdt_cnt_if.sv */
// carrier between the watchdog control logic and its prescale counter
// assumes both ends sit on the same system clock
`timescale 1ns/1ns
interface wdt_cnt_if;
    import wdt_pkg::*;
    logic             tick;    // one oscillator edge, one clk wide
    logic             clear;   // hold count at zero
    logic [4:0]       sel;     // period select code
    logic             expire;  // count reached the ratio, one clk wide
    logic [CNT_W-1:0] count;   // live count of oscillator ticks

    modport ctl (output tick, output clear, output sel, input expire, input count);
    modport cnt (input tick, input clear, input sel, output expire, output count);
endinterface

/* File: verilog/wdt_sync.sv */
// two-flop synchroniser for one asynchronous level
// assumes the level toggles far slower than clk
`timescale 1ns/1ns
module wdt_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic meta_ff;  // first stage, read only by the second

    // =========================================================================
    // two stages, no logic in between
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule

/* File: verilog/wdt_prescale.sv */
// prescale counter of oscillator ticks with period decode
// assumes tick is a one-clk pulse per low-frequency oscillator edge
`timescale 1ns/1ns
module wdt_prescale #(
    parameter int BASE_LOG2 = wdt_pkg::PS_BASE_LOG2  // divide by 2^BASE at code 0
) (
    input  wire logic clk,
    input  wire logic rst,
    wdt_cnt_if.cnt    cif
);
    import wdt_pkg::*;

    logic [4:0]       selEff;    // code after reserved fold-back
    logic [4:0]       shiftAmt;  // log2 of the ratio
    logic [CNT_W-1:0] terminal;  // last count value of a period
    logic [CNT_W-1:0] count_ff;  // ticks since last clear
    logic             expire_ff; // registered expiry pulse

    // =========================================================================
    // period decode: ratio doubles per code, reserved codes use 1:32
    always_comb begin
        selEff   = (cif.sel > PS_MAX) ? PS_MIN : cif.sel;
        shiftAmt = 5'(BASE_LOG2) + selEff;
        terminal = (CNT_W'(1) << shiftAmt) - CNT_W'(1);
    end

    // =========================================================================
    // counter; >= guards against a period shortened mid-count
    always_ff @(posedge clk) begin
        if (rst || cif.clear) begin
            count_ff  <= '0;
            expire_ff <= 1'b0;
        end else if (cif.tick) begin
            if (count_ff >= terminal) begin
                count_ff  <= '0;
                expire_ff <= 1'b1;
            end else begin
                count_ff  <= count_ff + CNT_W'(1);
                expire_ff <= 1'b0;
            end
        end else begin
            expire_ff <= 1'b0;
        end
    end

    assign cif.count  = count_ff;
    assign cif.expire = expire_ff;

    AST_RSVD_MIN: assert property (@(posedge clk) disable iff (rst)
        (cif.sel > PS_MAX) |-> (terminal == (CNT_W'(1) << BASE_LOG2) - CNT_W'(1)))
        else $error("reserved period code not folded to 1:32");
endmodule

/* File: verilog/wdt_top.sv */
// watchdog timer: mode decode, sleep tracking, clear logic, registers, irq
// assumes sleep, ost and clear inputs come from logic on clk; the
// low-frequency oscillator arrives as a free-running asynchronous level
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
module wdt_top #(
    parameter int BASE_LOG2 = wdt_pkg::PS_BASE_LOG2  // lower only to shorten simulation
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [3:0]        regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [7:0]        regRdData,
    input  wire wdt_pkg::wdt_mode_t watchdogModeConfig,
    input  wire logic              lowFreqInternalOsc,
    input  wire logic              clearWatchdogInstruction,
    input  wire logic              inSleep,
    input  wire logic              oscFailDetected,
    input  wire logic              oscStartupTimerRunning,
    input  wire logic              crystalClockMode,
    input  wire logic              intoscFreqSelectWrite,
    output logic                   wdtSystemReset,
    output logic                   wdtWakeUp,
    output logic                   timeoutStatusFlag,
    output logic                   powerdownStatusFlag,
    output logic                   irq
);
    import wdt_pkg::*;

    // =========================================================================
    // declarations
    wdt_cnt_if              cif ();           // link to the prescale counter
    logic                   lfSync;           // oscillator level on clk
    logic                   lfPrev_ff;        // previous synced level
    logic                   lfTick;           // one clk per rising osc edge
    logic [4:0]             periodSel_ff;     // watchdog_period_select
    logic                   softEnable_ff;    // soft_watchdog_enable
    wdt_state_t             state_ff;         // sleep tracking
    wdt_state_t             nxt_state;
    logic                   sleepPrev_ff;     // inSleep one clk ago
    logic                   sleepEntry;       // rising inSleep
    logic                   sleepExit;        // falling inSleep
    logic                   inSleepState;     // state is sleep
    logic                   active;           // watchdog allowed to count
    logic                   ostHold;          // crystal wake still waiting
    logic                   timeoutFlag_ff;   // timeout_status_flag
    logic                   powerdownFlag_ff; // powerdown_status_flag
    logic                   wakeUp_ff;        // registered wake pulse
    logic                   sysReset_ff;      // registered reset pulse
    logic [EVT_W-1:0]       evtStatus_ff;     // sticky events
    logic [EVT_W-1:0]       evtMask_ff;       // event mask
    logic [EVT_W-1:0]       evtSet;           // events raised this clk
    logic [7:0]             rdData_ff;        // read data, one clk after strobe
    logic [7:0]             ctrlView;         // control register as read

    // =========================================================================
    // oscillator time base: the counter only counts oscillator edges, so the
    // timeout keeps its length whatever the cpu clock does
    wdt_sync u_lf_sync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (lowFreqInternalOsc),
        .syncOut (lfSync)
    );

    // edge detect reads the second stage only
    always_ff @(posedge clk) begin
        if (rst) begin
            lfPrev_ff <= 1'b0;
        end else begin
            lfPrev_ff <= lfSync;
        end
    end

    assign lfTick = lfSync & ~lfPrev_ff;

    // =========================================================================
    // sleep tracking state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            sleepPrev_ff <= 1'b0;
        end else begin
            sleepPrev_ff <= inSleep;
        end
    end

    assign sleepEntry = inSleep & ~sleepPrev_ff;
    assign sleepExit  = ~inSleep & sleepPrev_ff;

    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_AWAKE: begin
                if (sleepEntry) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // crystal sources must wait for the start-up timer
                if (sleepExit) begin
                    nxt_state = crystalClockMode ? ST_OST_HOLD : ST_AWAKE;
                end
            end
            ST_OST_HOLD: begin
                if (inSleep) begin
                    nxt_state = ST_SLEEP;
                end else if (!oscStartupTimerRunning) begin
                    nxt_state = ST_AWAKE;
                end
            end
            default: begin
                nxt_state = ST_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_AWAKE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign inSleepState = (state_ff == ST_SLEEP);
    assign ostHold      = (state_ff == ST_OST_HOLD);

    // =========================================================================
    // mode decode; software enable only matters in mode 01
    // the mode field is a static configuration level, so no sync is needed;
    // an inactive watchdog clears its count instead of freezing it, which
    // means a disable and re-enable always starts a full fresh period
    always_comb begin
        case (watchdogModeConfig)
            MODE_ON:      active = 1'b1;
            MODE_NOSLEEP: active = ~inSleepState;
            MODE_SW:      active = softEnable_ff;
            MODE_OFF:     active = 1'b0;
            default:      active = 1'b0;
        endcase
    end

    // =========================================================================
    // counter hookup; the divider-select write is not a clear term, so a
    // cpu clock change does not disturb a running period
    assign cif.tick  = lfTick;
    assign cif.sel   = periodSel_ff;
    assign cif.clear = clearWatchdogInstruction | sleepEntry | sleepExit
                     | oscFailDetected | ~active | oscStartupTimerRunning
                     | ostHold;
    // intoscFreqSelectWrite deliberately absent from the clear terms

    wdt_prescale #(
        .BASE_LOG2 (BASE_LOG2)
    ) u_prescale (
        .clk (clk),
        .rst (rst),
        .cif (cif)
    );

    // =========================================================================
    // timeout outcome: reset while awake, wake-up while asleep
    always_ff @(posedge clk) begin
        if (rst) begin
            sysReset_ff <= 1'b0;
            wakeUp_ff   <= 1'b0;
        end else begin
            sysReset_ff <= cif.expire & ~inSleepState;
            wakeUp_ff   <= cif.expire & inSleepState;
        end
    end

    assign wdtSystemReset = sysReset_ff;
    assign wdtWakeUp      = wakeUp_ff;

    // =========================================================================
    // status flags; a timeout in the same clk as a clear still records
    always_ff @(posedge clk) begin
        if (rst) begin
            timeoutFlag_ff   <= 1'(FLAG_RESET_TO);
            powerdownFlag_ff <= 1'(FLAG_RESET_PD);
        end else if (cif.expire) begin
            timeoutFlag_ff   <= 1'b0;
        end else if (sleepEntry) begin
            timeoutFlag_ff   <= 1'b1;
            powerdownFlag_ff <= 1'b0;
        end else if (clearWatchdogInstruction) begin
            timeoutFlag_ff   <= 1'b1;
            powerdownFlag_ff <= 1'b1;
        end
    end

    assign timeoutStatusFlag   = timeoutFlag_ff;
    assign powerdownStatusFlag = powerdownFlag_ff;

    // =========================================================================
    // control register
    always_ff @(posedge clk) begin
        if (rst) begin
            periodSel_ff  <= PS_RESET;
            softEnable_ff <= EN_RESET;
        end else if (regWr && regAddr == ADDR_CTRL) begin
            periodSel_ff  <= regWrData[CTRL_PS_MSB:CTRL_PS_LSB];
            softEnable_ff <= regWrData[CTRL_EN_BIT];
        end
    end

    // =========================================================================
    // interrupt events; set wins over a write-one clear
    assign evtSet[EVT_SLEEP_BIT] = wakeUp_ff;
    assign evtSet[EVT_RST_BIT]   = sysReset_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            evtStatus_ff <= '0;
        end else if (regWr && regAddr == ADDR_EVT) begin
            evtStatus_ff <= (evtStatus_ff & ~regWrData[EVT_W-1:0]) | evtSet;
        end else begin
            evtStatus_ff <= evtStatus_ff | evtSet;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            evtMask_ff <= '0;
        end else if (regWr && regAddr == ADDR_MASK) begin
            evtMask_ff <= regWrData[EVT_W-1:0];
        end
    end

    assign irq = |(evtStatus_ff & evtMask_ff);

    // =========================================================================
    // read path; data stand only in the clk after the strobe
    always_comb begin
        ctrlView                          = 8'h00;  // bits 7-6 read zero
        ctrlView[CTRL_PS_MSB:CTRL_PS_LSB] = periodSel_ff;
        ctrlView[CTRL_EN_BIT]             = softEnable_ff;
    end

    always_ff @(posedge clk) begin
        if (rst || !regRd) begin
            rdData_ff <= 8'h00;
        end else begin
            case (regAddr)
                ADDR_CTRL:  rdData_ff <= ctrlView;
                ADDR_EVT:   rdData_ff <= {6'h00, evtStatus_ff};
                ADDR_MASK:  rdData_ff <= {6'h00, evtMask_ff};
                ADDR_FLAGS: rdData_ff <= {3'h0, state_ff, active,
                                          powerdownFlag_ff, timeoutFlag_ff};
                default:    rdData_ff <= 8'h00;  // unmapped reads zero
            endcase
        end
    end

    assign regRdData = rdData_ff;

    // =========================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_ON_ACTIVE: assert property (
        (watchdogModeConfig == MODE_ON) |-> active)
        else $error("mode 11 not active");

    AST_NOSLEEP_OFF: assert property (
        (watchdogModeConfig == MODE_NOSLEEP) |-> (active == !inSleepState))
        else $error("mode 10 activity wrong");

    AST_SW_FOLLOWS: assert property (
        (watchdogModeConfig == MODE_SW) |-> (active == softEnable_ff))
        else $error("mode 01 does not follow enable");

    AST_OFF_IDLE: assert property (
        (watchdogModeConfig == MODE_OFF) |=> (cif.count == '0) && !cif.expire)
        else $error("mode 00 counter moved");

    AST_RESET_PERIOD: assert property (
        $past(rst) |-> (periodSel_ff == PS_RESET) && !softEnable_ff)
        else $error("reset values of control wrong");

    AST_CLEAR_CMD: assert property (
        (clearWatchdogInstruction || oscFailDetected) |=> (cif.count == '0))
        else $error("clear event left count");

    AST_SLEEP_ENTRY: assert property (
        sleepEntry |=> (cif.count == '0) ##1 (state_ff == ST_SLEEP || !inSleep))
        else $error("sleep entry did not clear");

    AST_OST_HOLD: assert property (
        ostHold && $past(ostHold) |-> (cif.count == '0))
        else $error("count moved during ost hold");

    AST_SLEEP_WAKE: assert property (
        (cif.expire && inSleepState) |=> wdtWakeUp && !wdtSystemReset && !timeoutStatusFlag)
        else $error("sleep timeout handled wrong");

    AST_AWAKE_RST: assert property (
        (cif.expire && !inSleepState) |=> wdtSystemReset ##1 !wdtSystemReset)
        else $error("awake timeout gave no reset pulse");

    AST_IRQ_LEVEL: assert property (
        $rose(evtStatus_ff[EVT_RST_BIT]) && evtMask_ff[EVT_RST_BIT] |-> irq)
        else $error("unmasked event did not raise irq");

    // count may only move on an oscillator tick or a clear, never on the cpu clock alone
    AST_COUNT_HOLD: assert property (
        (!lfTick && !cif.clear) |=> $stable(cif.count))
        else $error("count moved without an oscillator tick");

    AST_SLEEP_FLAGS: assert property (
        (sleepEntry && !cif.expire) |=> timeoutStatusFlag && !powerdownStatusFlag)
        else $error("sleep entry flags wrong");

    AST_CTRL_UPPER: assert property (
        $past(regRd) && ($past(regAddr) == ADDR_CTRL) |-> (regRdData[7:6] == 2'b00))
        else $error("control bits 7-6 not zero");

    COV_WAKE: cover property (wdtWakeUp);
    COV_RESET: cover property (wdtSystemReset);
    COV_OST: cover property (ostHold ##[1:8] (state_ff == ST_AWAKE));
    // reserved code timing out and a software-mode wake from sleep
    COV_RSVD: cover property ((cif.sel > PS_MAX) && cif.expire);
    COV_SW_WAKE: cover property ((watchdogModeConfig == MODE_SW) && wdtWakeUp);
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the watchdog timer top module
// assumes wdt_pkg and the design files are compiled first
`timescale 1ns/1ns
module tb_top;
    import wdt_pkg::*;
    // =========================================================================
    // stimulus and observed signals
    logic       clk = 1'b0;                  // 25 MHz system clock
    logic       rst = 1'b1;                  // synchronous reset
    logic [3:0] regAddr = 4'h0;              // register word address
    logic [7:0] regWrData = 8'h00;           // write data
    logic       regWr = 1'b0;                // write strobe
    logic       regRd = 1'b0;                // read strobe
    logic [7:0] regRdData;                   // read data
    wdt_mode_t  watchdogModeConfig = MODE_OFF; // configuration mode field
    logic       lowFreqInternalOsc = 1'b0;   // oscillator level
    logic [3:0] oscDiv = 4'h0;               // oscillator divider
    logic       clearWatchdogInstruction = 1'b0;
    logic       inSleep = 1'b0;
    logic       oscFailDetected = 1'b0;
    logic       oscStartupTimerRunning = 1'b0;
    logic       crystalClockMode = 1'b0;
    logic       intoscFreqSelectWrite = 1'b0;
    logic       wdtSystemReset, wdtWakeUp, timeoutStatusFlag, powerdownStatusFlag, irq;
    int         errorCnt = 0;                // mismatches
    int         nTests = 0;                  // comparisons
    // =========================================================================
    // design, periods shortened: code 0 counts 2 ticks
    wdt_top #(.BASE_LOG2(1)) i_wdt_top (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .watchdogModeConfig(watchdogModeConfig), .lowFreqInternalOsc(lowFreqInternalOsc),
        .clearWatchdogInstruction(clearWatchdogInstruction), .inSleep(inSleep),
        .oscFailDetected(oscFailDetected), .oscStartupTimerRunning(oscStartupTimerRunning),
        .crystalClockMode(crystalClockMode), .intoscFreqSelectWrite(intoscFreqSelectWrite),
        .wdtSystemReset(wdtSystemReset), .wdtWakeUp(wdtWakeUp),
        .timeoutStatusFlag(timeoutStatusFlag), .powerdownStatusFlag(powerdownStatusFlag),
        .irq(irq));
    // clock, half period 20 ns
    always #20 clk = ~clk;
    // oscillator runs free at 1/16 of clk, far faster than real to keep runs short
    always @(posedge clk) begin
        oscDiv <= oscDiv + 4'h1;
        lowFreqInternalOsc <= oscDiv[3];
    end
    // =========================================================================
    // shared tasks
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) begin
            regAddr <= a;
            regWrData <= d;
            regWr <= 1'b1;
        end
        @(posedge clk) regWr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk) begin
            regAddr <= a;
            regRd <= 1'b1;
        end
        @(posedge clk) regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    // count timeout pulses over n cycles
    task automatic watch(input int n, output int nr, output int nw);
        nr = 0;
        nw = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            nr += int'(wdtSystemReset === 1'b1);
            nw += int'(wdtWakeUp === 1'b1);
        end
    endtask
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // =========================================================================
    // scenarios
    task automatic t_reset;
        logic [7:0] d;
        rd(ADDR_CTRL, d);
        chk("ctrl reset", d, 8'h16);
        rd(ADDR_FLAGS, d);
        chk("flags reset", d, 8'h03);
        wr(ADDR_CTRL, 8'hff);
        rd(ADDR_CTRL, d);
        chk("ctrl upper bits", d, 8'h3f);
        wr(4'h9, 8'h5a);
        rd(4'h9, d);
        chk("unmapped", d, 8'h00);
        $display("test reset done");
    endtask
    // measured timeout against the decoded ratio, reserved codes included
    task automatic t_period;
        logic [4:0] sels [4] = '{5'h00, 5'h03, 5'h13, 5'h1f};
        int r, n;
        foreach (sels[i]) begin
            r = 2 << ((sels[i] > 5'h12) ? 0 : sels[i]);
            watchdogModeConfig <= MODE_OFF;
            wr(ADDR_CTRL, {2'h0, sels[i], 1'b0});
            repeat (4) @(posedge clk);
            watchdogModeConfig <= MODE_ON;
            n = 0;
            while (wdtSystemReset !== 1'b1 && n < 9000) begin
                @(posedge clk);
                #1 n++;
            end
            chk("period", 8'(n >= (r - 1) * 16 && n <= r * 16 + 8), 8'h01);
            chk("timeout flag", 8'(timeoutStatusFlag), 8'h00);
        end
        $display("test period done");
    endtask
    // every mode against enable and sleep, packed {mode, en, sleep, reset, wake}
    task automatic t_modes;
        logic [5:0] cases [8] = '{6'h08, 6'h10, 6'h1a, 6'h22, 6'h2c, 6'h35, 6'h1d, 6'h32};
        int nr, nw;
        foreach (cases[i]) begin
            watchdogModeConfig <= MODE_OFF;
            wr(ADDR_CTRL, {7'h00, cases[i][3]});
            watchdogModeConfig <= wdt_mode_t'(cases[i][5:4]);
            inSleep <= cases[i][2];
            repeat (5) @(posedge clk);
            #1;
            if (cases[i][2]) chk("sleep entry", {timeoutStatusFlag, powerdownStatusFlag}, 8'h02);
            watch(150, nr, nw);
            chk("reset seen", 8'(nr > 0), 8'(cases[i][1]));
            chk("wake seen", 8'(nw > 0), 8'(cases[i][0]));
            if (cases[i][0]) chk("wake flags", {timeoutStatusFlag, powerdownStatusFlag}, 8'h00);
            inSleep <= 1'b0;
            repeat (4) @(posedge clk);
        end
        $display("test modes done");
    endtask
    // clearing terms hold the count, the divider write does not
    task automatic t_clears;
        int nr, nw, s;
        logic [7:0] d;
        watchdogModeConfig <= MODE_ON;
        oscFailDetected <= 1'b1;
        repeat (2) @(posedge clk);
        watch(150, nr, nw);
        chk("osc fail holds", 8'(nr), 8'h00);
        oscFailDetected <= 1'b0;
        s = 0;
        repeat (20) begin
            @(posedge clk) clearWatchdogInstruction <= 1'b1;
            @(posedge clk) clearWatchdogInstruction <= 1'b0;
            watch(6, nr, nw);
            s += nr;
        end
        chk("clear instr holds", 8'(s), 8'h00);
        chk("clear flags", {timeoutStatusFlag, powerdownStatusFlag}, 8'h03);
        intoscFreqSelectWrite <= 1'b1;
        watch(150, nr, nw);
        chk("divider write", 8'(nr > 0), 8'h01);
        intoscFreqSelectWrite <= 1'b0;
        crystalClockMode <= 1'b1;
        inSleep <= 1'b1;
        repeat (5) @(posedge clk);
        inSleep <= 1'b0;
        oscStartupTimerRunning <= 1'b1;
        watch(150, nr, nw);
        chk("ost hold", 8'(nr + nw), 8'h00);
        rd(ADDR_FLAGS, d);
        chk("ost state", {6'h00, d[4:3]}, 8'h02);
        oscStartupTimerRunning <= 1'b0;
        watch(150, nr, nw);
        chk("after ost", 8'(nr > 0), 8'h01);
        crystalClockMode <= 1'b0;
        $display("test clears done");
    endtask
    // sticky events, mask and write-one-to-clear
    task automatic t_irq;
        logic [7:0] d;
        watchdogModeConfig <= MODE_OFF;
        repeat (8) @(posedge clk);
        rd(ADDR_EVT, d);
        chk("events", d, 8'h03);
        chk("irq masked", 8'(irq), 8'h00);
        wr(ADDR_MASK, 8'h01);
        #1 chk("irq on", 8'(irq), 8'h01);
        wr(ADDR_EVT, 8'h01);
        #1 chk("irq cleared", 8'(irq), 8'h00);
        rd(ADDR_EVT, d);
        chk("event left", d, 8'h02);
        wr(ADDR_MASK, 8'h03);
        #1 chk("irq second", 8'(irq), 8'h01);
        wr(ADDR_EVT, 8'h02);
        #1 chk("irq off", 8'(irq), 8'h00);
        $display("test irq done");
    endtask
    // =========================================================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_period();
        t_modes();
        t_clears();
        t_irq();
        printVerdict();
    end
    // runs need about 2.5k cycles; cut off well beyond that
    initial begin
        #(40 * 60000);
        errorCnt++;
        printVerdict();
    end
endmodule
